//--- trouble_supervision_annunciator.sv
`timescale 1ns/1ps
`default_nettype none
module trouble_supervision_annunciator
   import trouble_pkg::*;
(
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst,
   // Integrity fault inputs, one bit per source, active high
   input  wire logic [NUM_SOURCES-1:0] fault_in,
   // Extra controller sources outside fault_in; each also raises the trouble summary
   input  wire logic                   play_resistor_fault,
   input  wire logic                   charger_fault,
   // Controller main power fuse blown, active high
   input  wire logic                   ctrl_fuse_blown,
   // Operator acknowledge button, active high
   input  wire logic                   ack_button,
   // Status lamps and relay
   output logic                        normal_lamp,
   output logic                        trouble_lamp,
   output logic                        trouble_relay,
   // Audibles
   output logic                        internal_sounder,
   output logic                        external_audible,
   // Power module location lamps
   output logic                        input_power_low_lamp,
   output logic                        battery_voltage_low_lamp,
   output logic                        battery_open_lamp,
   // Amplifier module location lamps
   output logic                        amplifier_fault_lamp,
   output logic                        speaker_wiring_fault_lamp,
   output logic                        visual_wiring_fault_lamp,
   output logic                        speaker_power_wiring_lamp,
   // Controller module location lamps
   output logic                        play_resistor_missing_lamp,
   output logic                        charger_fault_lamp,
   output logic                        remote_mic_fault_lamp
);
   logic any_trouble;
   logic ack_press;
   logic silenced;

   // Any supervised source, or either extra controller source, is a trouble
   assign any_trouble = (|fault_in) | play_resistor_fault | charger_fault;

   ack_sync_edge u_ack (
      .clock      (clock),
      .rst        (rst),
      .ack_button (ack_button),
      .ack_press  (ack_press)
   );

   silence_latch u_silence (
      .clock       (clock),
      .rst         (rst),
      .any_trouble (any_trouble),
      .ack_press   (ack_press),
      .silenced    (silenced)
   );

   // Next values for all outputs; acknowledge only reaches the audibles
   logic status_n_d, status_t_d, relay_d, snd_d;
   logic [9:0] loc_d;
   always_comb begin
      status_n_d = ~any_trouble;
      status_t_d = any_trouble;
      relay_d    = any_trouble ? RELAY_TROUBLE : RELAY_NORMAL;
      snd_d      = any_trouble & ~silenced & ~ctrl_fuse_blown;
      loc_d[0]   = fault_in[SRC_MAINS_LOW];
      loc_d[1]   = fault_in[SRC_BATTERY_LOW];
      loc_d[2]   = fault_in[SRC_BATTERY_OPEN];
      loc_d[3]   = fault_in[SRC_AMPLIFIER] | fault_in[SRC_INT_WIRING];
      loc_d[4]   = fault_in[SRC_SPEAKER_WIRING] | fault_in[SRC_AMP_AUDIO];
      loc_d[5]   = fault_in[SRC_STROBE_WIRING];
      loc_d[6]   = fault_in[SRC_AMP_POWER];
      loc_d[7]   = play_resistor_fault;
      loc_d[8]   = charger_fault;
      loc_d[9]   = fault_in[SRC_REMOTE_MIC];
   end

   // Registered outputs; reset shows normal so lamps are never both dark
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         normal_lamp      <= 1'h1;
         trouble_lamp     <= 1'h0;
         trouble_relay    <= RELAY_NORMAL;
         internal_sounder <= 1'h0;
         external_audible <= 1'h0;
         {remote_mic_fault_lamp, charger_fault_lamp, play_resistor_missing_lamp,
          speaker_power_wiring_lamp, visual_wiring_fault_lamp,
          speaker_wiring_fault_lamp, amplifier_fault_lamp, battery_open_lamp,
          battery_voltage_low_lamp, input_power_low_lamp} <= 10'h000;
      end else begin
         normal_lamp      <= status_n_d;
         trouble_lamp     <= status_t_d;
         trouble_relay    <= relay_d;
         internal_sounder <= snd_d;
         external_audible <= snd_d;
         {remote_mic_fault_lamp, charger_fault_lamp, play_resistor_missing_lamp,
          speaker_power_wiring_lamp, visual_wiring_fault_lamp,
          speaker_wiring_fault_lamp, amplifier_fault_lamp, battery_open_lamp,
          battery_voltage_low_lamp, input_power_low_lamp} <= loc_d;
      end
   end

   // Checks
   a_lamps_exclusive: assert property (@(posedge clock) disable iff (rst)
      normal_lamp != trouble_lamp) else $error("status lamps equal");
   a_trouble_lamp_follows: assert property (@(posedge clock) disable iff (rst)
      any_trouble |=> trouble_lamp && !normal_lamp) else $error("trouble lamp late");
   a_normal_lamp_follows: assert property (@(posedge clock) disable iff (rst)
      !any_trouble |=> normal_lamp && !trouble_lamp) else $error("normal lamp wrong");
   a_relay_follows: assert property (@(posedge clock) disable iff (rst)
      any_trouble |=> trouble_relay == RELAY_TROUBLE) else $error("relay wrong");
   a_sound_on_fault: assert property (@(posedge clock) disable iff (rst)
      any_trouble && !silenced && !ctrl_fuse_blown |=> internal_sounder && external_audible)
      else $error("audible missing");
   a_fuse_mutes: assert property (@(posedge clock) disable iff (rst)
      ctrl_fuse_blown |=> !internal_sounder && !external_audible) else $error("fuse not muting");
   a_ack_silences: assert property (@(posedge clock) disable iff (rst)
      ack_press && any_trouble ##1 any_trouble |=> !internal_sounder)
      else $error("ack did not silence");
   a_ack_keeps_lamps: assert property (@(posedge clock) disable iff (rst)
      silenced && any_trouble |=> trouble_lamp && trouble_relay == RELAY_TROUBLE)
      else $error("ack hit lamps");
   a_silence_clears: assert property (@(posedge clock) disable iff (rst)
      !any_trouble |=> !silenced) else $error("silence outlived trouble");
   a_batt_low_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_BATTERY_LOW] |=> battery_voltage_low_lamp) else $error("battery lamp");
   a_batt_open_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_BATTERY_OPEN] |=> battery_open_lamp) else $error("open lamp");
   a_amp_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_AMPLIFIER] |=> amplifier_fault_lamp) else $error("amplifier lamp");
   a_audio_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_SPEAKER_WIRING] |=> speaker_wiring_fault_lamp)
      else $error("audio wiring lamp");
   a_visual_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_STROBE_WIRING] |=> visual_wiring_fault_lamp)
      else $error("visual wiring lamp");
   a_spk_power_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_AMP_POWER] |=> speaker_power_wiring_lamp)
      else $error("speaker power lamp");
   a_play_lamp: assert property (@(posedge clock) disable iff (rst)
      play_resistor_fault |=> play_resistor_missing_lamp) else $error("play lamp");
   a_charger_lamp: assert property (@(posedge clock) disable iff (rst)
      charger_fault |=> charger_fault_lamp) else $error("charger lamp");
   a_silence_holds: assert property (@(posedge clock) disable iff (rst)
      silenced && $stable(silenced) && any_trouble |=> !external_audible)
      else $error("silence broke");
   a_mains_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_MAINS_LOW] |=> input_power_low_lamp) else $error("mains lamp");
   a_mic_lamp: assert property (@(posedge clock) disable iff (rst)
      fault_in[SRC_REMOTE_MIC] |=> remote_mic_fault_lamp) else $error("mic lamp");
   c_trouble_seen: cover property (@(posedge clock) disable iff (rst) !any_trouble ##1 any_trouble);
   c_silenced: cover property (@(posedge clock) disable iff (rst) ack_press && any_trouble);
   c_resound: cover property (@(posedge clock) disable iff (rst)
      silenced ##1 !any_trouble ##1 any_trouble);
   c_fuse_mute: cover property (@(posedge clock) disable iff (rst) ctrl_fuse_blown && any_trouble);
endmodule
`default_nettype wire

//--- trouble_pkg.sv
package trouble_pkg;
   // Number of supervised trouble sources
   localparam int unsigned NUM_SOURCES = 11;
   // Index of each source in the trouble vector
   localparam int unsigned SRC_STROBE_WIRING  = 0;
   localparam int unsigned SRC_SPEAKER_WIRING = 1;
   localparam int unsigned SRC_AMP_AUDIO      = 2;
   localparam int unsigned SRC_AMP_POWER      = 3;
   localparam int unsigned SRC_MAINS_LOW      = 4;
   localparam int unsigned SRC_BATTERY_LOW    = 5;
   localparam int unsigned SRC_BATTERY_OPEN   = 6;
   localparam int unsigned SRC_AMPLIFIER      = 7;
   localparam int unsigned SRC_INT_WIRING     = 8;
   localparam int unsigned SRC_INT_FUSE       = 9;
   localparam int unsigned SRC_REMOTE_MIC     = 10;
   // Relay position encoding: 1 means trouble position
   localparam logic RELAY_NORMAL  = 1'h0;
   localparam logic RELAY_TROUBLE = 1'h1;
   // Acknowledge synchroniser depth
   localparam int unsigned SYNC_STAGES = 2;
   // Silence latch states
   typedef enum logic [1:0] {
      SIL_IDLE,
      SIL_SOUNDING,
      SIL_SILENCED
   } silence_state_t;
endpackage

//--- ack_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module ack_sync_edge
   import trouble_pkg::*;
#(
   parameter int unsigned STAGES = SYNC_STAGES
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Raw button and press pulse
   input  wire logic ack_button,
   output logic      ack_press
);
   logic [STAGES-1:0] sync_q;
   logic [STAGES-1:0] sync_d;
   logic              last_q;
   logic              last_d;

   // Shift chain; only the last stage feeds the edge detector
   always_comb begin
      sync_d = {sync_q[STAGES-2:0], ack_button};
      last_d = sync_q[STAGES-1];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_q <= '0;
         last_q <= 1'h0;
      end else begin
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   // Rising edge of the synchronised level
   assign ack_press = sync_q[STAGES-1] & ~last_q;
endmodule
`default_nettype wire

//--- silence_latch.sv
`timescale 1ns/1ps
`default_nettype none
module silence_latch
   import trouble_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Trouble summary and acknowledge press
   input  wire logic any_trouble,
   input  wire logic ack_press,
   // Silence state
   output logic      silenced
);
   silence_state_t state_q;
   silence_state_t state_d;

   // Silence holds until the trouble summary falls to zero
   always_comb begin
      state_d = state_q;
      case (state_q)
         SIL_IDLE: begin
            if (any_trouble && ack_press) state_d = SIL_SILENCED;
            else if (any_trouble) state_d = SIL_SOUNDING;
         end
         SIL_SOUNDING: begin
            if (!any_trouble) state_d = SIL_IDLE;
            else if (ack_press) state_d = SIL_SILENCED;
         end
         SIL_SILENCED: begin
            if (!any_trouble) state_d = SIL_IDLE;
         end
         default: state_d = SIL_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) state_q <= SIL_IDLE;
      else state_q <= state_d;
   end

   // Press with no trouble present is ignored, so silence is never pre-armed
   assign silenced = (state_q == SIL_SILENCED);
endmodule
`default_nettype wire

//--- operator_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module operator_panel_model #(
   parameter int HOLD = 2
) (
   // Clock
   input  wire logic clock,
   // Press request from the bench
   input  wire logic press_req,
   // Button contact
   output logic      ack_button
);
   int   cnt;
   logic req;
   initial begin
      ack_button = 1'h0;
      cnt = 0;
   end
   // Held for two cycles so the two-stage synchroniser cannot miss it
   always @(posedge clock) begin
      req = press_req;
      #1;
      if (cnt > 0) cnt--;
      else if (req) cnt = HOLD;
      ack_button = (cnt > 0);
   end
endmodule
`default_nettype wire

//--- trouble_supervision_annunciator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module trouble_supervision_annunciator_tb_top
   import trouble_pkg::*;
;
   logic                   clock = 1'h0;
   logic                   rst = 1'h1;
   logic [NUM_SOURCES-1:0] fault_in = '0;
   logic                   play_resistor_fault = 1'h0;
   logic                   charger_fault = 1'h0;
   logic                   ctrl_fuse_blown = 1'h0;
   logic                   press_req = 1'h0;
   wire logic              ack_button;
   logic normal_lamp, trouble_lamp, trouble_relay, internal_sounder, external_audible;
   logic input_power_low_lamp, battery_voltage_low_lamp, battery_open_lamp;
   logic amplifier_fault_lamp, speaker_wiring_fault_lamp, visual_wiring_fault_lamp;
   logic speaker_power_wiring_lamp, play_resistor_missing_lamp, charger_fault_lamp;
   logic remote_mic_fault_lamp;
   int   error_cnt = 0;
   int   num_checks = 0;
   int   cycles = 0;

   trouble_supervision_annunciator uut (.clock(clock), .rst(rst), .fault_in(fault_in),
      .play_resistor_fault(play_resistor_fault), .charger_fault(charger_fault),
      .ctrl_fuse_blown(ctrl_fuse_blown), .ack_button(ack_button),
      .normal_lamp(normal_lamp), .trouble_lamp(trouble_lamp), .trouble_relay(trouble_relay),
      .internal_sounder(internal_sounder), .external_audible(external_audible),
      .input_power_low_lamp(input_power_low_lamp),
      .battery_voltage_low_lamp(battery_voltage_low_lamp),
      .battery_open_lamp(battery_open_lamp), .amplifier_fault_lamp(amplifier_fault_lamp),
      .speaker_wiring_fault_lamp(speaker_wiring_fault_lamp),
      .visual_wiring_fault_lamp(visual_wiring_fault_lamp),
      .speaker_power_wiring_lamp(speaker_power_wiring_lamp),
      .play_resistor_missing_lamp(play_resistor_missing_lamp),
      .charger_fault_lamp(charger_fault_lamp), .remote_mic_fault_lamp(remote_mic_fault_lamp));
   operator_panel_model panel (.clock(clock), .press_req(press_req), .ack_button(ack_button));

   // 200 MHz clock
   always #2.5 clock = ~clock;

   // Hang guard, far above the 78 cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles >= 2000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic press();
      press_req = 1'h1;
      step(1);
      press_req = 1'h0;
      step(8);
   endtask
   // Status lamps, relay and both audibles against trouble and sound levels
   task automatic status(input logic t, input logic s);
      check("normal_lamp", {9'h0, normal_lamp}, {9'h0, !t});
      check("trouble_lamp", {9'h0, trouble_lamp}, {9'h0, t});
      check("trouble_relay", {9'h0, trouble_relay}, {9'h0, t});
      check("internal_sounder", {9'h0, internal_sounder}, {9'h0, s});
      check("external_audible", {9'h0, external_audible}, {9'h0, s});
   endtask
   // Location lamps against the source that should light each
   task automatic locs();
      check("location_lamps", {input_power_low_lamp, battery_voltage_low_lamp,
         battery_open_lamp, amplifier_fault_lamp, speaker_wiring_fault_lamp,
         visual_wiring_fault_lamp, speaker_power_wiring_lamp, play_resistor_missing_lamp,
         charger_fault_lamp, remote_mic_fault_lamp}, {fault_in[4], fault_in[5], fault_in[6],
         fault_in[7] | fault_in[8], fault_in[1] | fault_in[2], fault_in[0], fault_in[3],
         play_resistor_fault, charger_fault, fault_in[10]});
   endtask
   task automatic test_done();
      if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      step(8);
      rst = 1'h0;
      step(2);
      status(1'h0, 1'h0);
      // Every source alone, each sounding afresh
      for (int i = 0; i < 13; i++) begin
         {charger_fault, play_resistor_fault, fault_in} = 13'h0001 << i;
         step(1);
         status(1'h1, 1'h1);
         locs();
         {charger_fault, play_resistor_fault, fault_in} = 13'h0000;
         step(2);
         status(1'h0, 1'h0);
      end
      // Acknowledge silences, indications stay
      fault_in = 11'h010;
      step(1);
      press();
      status(1'h1, 1'h0);
      locs();
      fault_in = 11'h096;
      step(2);
      status(1'h1, 1'h0);
      locs();
      fault_in = 11'h000;
      step(2);
      fault_in = 11'h001;
      step(1);
      status(1'h1, 1'h1);
      fault_in = 11'h000;
      step(2);
      // Acknowledge with nothing wrong must not pre-silence
      press();
      fault_in = 11'h400;
      step(1);
      status(1'h1, 1'h1);
      // Blown controller fuse mutes only the audibles
      ctrl_fuse_blown = 1'h1;
      step(1);
      status(1'h1, 1'h0);
      locs();
      ctrl_fuse_blown = 1'h0;
      step(1);
      status(1'h1, 1'h1);
      test_done();
   end
endmodule
`default_nettype wire
